// ### design/adcrp_pkg.sv
// Contract
// - Parallel pins driven only with read_convert high and chip select low.
// - Byte select low gives upper byte, high gives lower byte.
// - Byte select may toggle mid-cycle; presented byte follows it.
// - Result contents are undefined until the first conversion completes.
// - Conversion end updates result and raises busy; result then readable.
// - Output format low selects serial delivery, internal or external clock.
// - Internal clock: bit clock always driven; serial line driven while busy low.
// - External clock: serial line driven only with chip select low, read high.
// - Serial modes: frame pulse always output, daisy input always input.
// - Internal clock: conversion start shifts previous result over 16 pulses.
// - External clock, busy high: enable gives frame pulse, then result bits.
// - External clock: after result, daisy input follows delayed 16 clocks.
// - Continuous mode: falling select or read_convert restarts conversions.
// - Results two's complement, serial MSB first.
// - Select and read_convert low 40ns start conversion; busy drops.
// - Conversion requests while busy low are ignored.
// - Internal clock: after 16th pulse clock low, line takes first daisy level.
package adcrp_pkg;

  localparam int CLK_NS          = 20;
  localparam int RESULT_W        = 16;
  localparam int BYTE_W          = 8;
  localparam int FIFO_DEPTH      = 32;
  localparam int CNT_W           = 10;

  localparam int START_NS        = 40;
  localparam int START_CYC       = (START_NS + CLK_NS - 1) / CLK_NS;
  localparam int CONV_NS         = 20000;
  localparam int CONV_CYC        = CONV_NS / CLK_NS;
  localparam int DCLK_DELAY_NS   = 1400;
  localparam int DCLK_DELAY_CYC  = DCLK_DELAY_NS / CLK_NS;
  localparam int DCLK_PERIOD_NS  = 1100;
  localparam int DCLK_HALF_CYC   = DCLK_PERIOD_NS / 2 / CLK_NS;
  localparam int SERIAL_BITS     = 16;

  localparam logic [2:0]          START_LAST = 3'(START_CYC - 1);
  localparam logic [CNT_W-1:0]    CONV_LAST  = CNT_W'(CONV_CYC - 1);
  localparam logic [CNT_W-1:0]    DELAY_LOAD = CNT_W'(DCLK_DELAY_CYC - 1);
  localparam logic [CNT_W-1:0]    HALF_LOAD  = CNT_W'(DCLK_HALF_CYC - 1);
  localparam logic [4:0]          LAST_PULSE = 5'(SERIAL_BITS - 1);
  localparam logic [RESULT_W-1:0] RESULT_RST = 16'h0000;

  typedef struct packed {
    logic chip_select_n;
    logic read_convert;
    logic byte_select;
    logic output_format_select;
    logic clock_source_select;
    logic continuous_convert_select;
    logic power_down_input;
    logic daisy_chain_input;
    logic bit_clock_in;
  } adcrp_pins_t;

  // Idle levels, so a flushed synchroniser never fakes a start request
  localparam adcrp_pins_t PINS_RST = 9'h180;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CONV = 2'b01,
    ST_LOAD = 2'b10
  } adcrp_state_t;

endpackage : adcrp_pkg

// ### design/adcrp_readout.sv
`timescale 1ns/100ps
`default_nettype none

module adcrp_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
) (
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output var  logic             in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_q;
  logic [AW-1:0]    rd_ptr_q;
  logic [AW:0]      count_q;
  logic [AW:0]      count_d;
  wire              push = in_valid & in_ready;
  wire              pop  = out_valid & out_ready;

  assign out_valid = (count_q != '0);
  assign out_data  = mem[rd_ptr_q];
  assign count_d   = (push & ~pop) ? count_q + 1'b1 :
                     (pop & ~push) ? count_q - 1'b1 : count_q;

  // Ready is registered so the top can drive it straight from a flop
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
      in_ready <= 1'b0;
    end else begin
      wr_ptr_q <= wr_ptr_q + AW'(push);
      rd_ptr_q <= rd_ptr_q + AW'(pop);
      count_q  <= count_d;
      in_ready <= (count_d != (AW+1)'(DEPTH));
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_q] <= in_data;
    end
  end

endmodule : adcrp_fifo

module adcrp_readout
  import adcrp_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                sys_rst,
  input  wire logic                chip_select_n,
  input  wire logic                read_convert,
  input  wire logic                byte_select,
  input  wire logic                output_format_select,
  input  wire logic                clock_source_select,
  input  wire logic                continuous_convert_select,
  input  wire logic                power_down_input,
  input  wire logic                daisy_chain_input,
  input  wire logic                serial_bit_clock_i,
  input  wire logic [RESULT_W-1:0] sample_data,
  input  wire logic                sample_valid,
  output var  logic                sample_ready,
  output var  logic                busy_n,
  output var  logic [BYTE_W-1:0]   parallel_data,
  output var  logic [BYTE_W-1:0]   parallel_data_oe,
  output var  logic                serial_bit_clock_o,
  output var  logic                serial_bit_clock_oe,
  output var  logic                serial_output_line,
  output var  logic                serial_output_line_oe,
  output var  logic                frame_pulse
);

  adcrp_pins_t  pins_raw;
  adcrp_pins_t  pins_meta_q;
  adcrp_pins_t  pins_q;
  adcrp_pins_t  pins_prev_q;
  adcrp_state_t state_q;
  logic [2:0]          low_cnt_q;
  logic [CNT_W-1:0]    conv_cnt_q;
  logic [RESULT_W-1:0] result_q;
  logic [RESULT_W-1:0] shift_q;
  logic                int_active_q;
  logic [CNT_W-1:0]    int_tmr_q;
  logic [4:0]          int_pulses_q;
  logic                int_done_q;
  logic                tag_cap_q;
  logic [1:0]          ext_cnt_q;
  logic                ext_en_prev_q;
  logic                frame_q;
  logic                ser_q;
  logic [RESULT_W-1:0] fifo_data;
  logic                fifo_valid;

  // Every pin crosses two flops before any logic reads it
  assign pins_raw = '{chip_select_n:             chip_select_n,
                      read_convert:              read_convert,
                      byte_select:               byte_select,
                      output_format_select:      output_format_select,
                      clock_source_select:       clock_source_select,
                      continuous_convert_select: continuous_convert_select,
                      power_down_input:          power_down_input,
                      daisy_chain_input:         daisy_chain_input,
                      bit_clock_in:              serial_bit_clock_i};

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pins_meta_q <= PINS_RST;
      pins_q      <= PINS_RST;
      pins_prev_q <= PINS_RST;
    end else begin
      pins_meta_q <= pins_raw;
      pins_q      <= pins_meta_q;
      pins_prev_q <= pins_q;
    end
  end

  wire serial_mode  = ~pins_q.output_format_select;
  wire ext_clk_mode = serial_mode & pins_q.clock_source_select;
  wire int_clk_mode = serial_mode & ~pins_q.clock_source_select;
  wire read_sel     = ~pins_q.chip_select_n & pins_q.read_convert;
  wire both_low     = ~pins_q.chip_select_n & ~pins_q.read_convert;
  wire held_long    = both_low & (low_cnt_q >= START_LAST);
  wire fall_edge    = (pins_prev_q.chip_select_n & ~pins_q.chip_select_n) |
                      (pins_prev_q.read_convert & ~pins_q.read_convert);
  wire cont_restart = pins_q.continuous_convert_select & both_low & fall_edge;
  wire start_go     = (state_q == ST_IDLE) & ~pins_q.power_down_input &
                      (held_long | cont_restart);
  wire conv_end     = (state_q == ST_LOAD) & fifo_valid;
  wire ext_en       = ext_clk_mode & read_sel;
  wire ext_rise     = pins_q.bit_clock_in & ~pins_prev_q.bit_clock_in;
  wire ext_arm      = ext_en & ~ext_en_prev_q & busy_n;
  // Loading while the external clock is high drops the new word
  wire ext_reload   = conv_end & ext_en & ~pins_q.bit_clock_in;
  wire int_edge     = int_active_q & (int_tmr_q == '0);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      low_cnt_q <= '0;
    end else if (!both_low) begin
      low_cnt_q <= '0;
    end else if (low_cnt_q != 3'h7) begin
      low_cnt_q <= low_cnt_q + 3'h1;
    end
  end

  // Conversion sequencer; results come from the sample FIFO
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q    <= ST_IDLE;
      conv_cnt_q <= '0;
      busy_n     <= 1'b1;
      result_q   <= RESULT_RST;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (start_go) begin
            state_q    <= ST_CONV;
            conv_cnt_q <= '0;
            busy_n     <= 1'b0;
          end
        end
        ST_CONV: begin
          conv_cnt_q <= conv_cnt_q + 1'b1;
          if (conv_cnt_q == CONV_LAST) begin
            state_q <= ST_LOAD;
          end
        end
        ST_LOAD: begin
          // Stalls with busy low until a sample is available
          if (fifo_valid) begin
            result_q <= fifo_data;
            busy_n   <= 1'b1;
            state_q  <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
          busy_n  <= 1'b1;
        end
      endcase
    end
  end

  // Internal bit clock: delay, then 16 pulses from the divider
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      int_active_q       <= 1'b0;
      int_tmr_q          <= '0;
      int_pulses_q       <= '0;
      int_done_q         <= 1'b0;
      tag_cap_q          <= 1'b0;
      serial_bit_clock_o <= 1'b0;
    end else if (start_go && int_clk_mode) begin
      int_active_q       <= 1'b1;
      int_tmr_q          <= DELAY_LOAD;
      int_pulses_q       <= '0;
      int_done_q         <= 1'b0;
      serial_bit_clock_o <= 1'b0;
    end else if (int_active_q) begin
      int_tmr_q <= (int_tmr_q == '0) ? HALF_LOAD : int_tmr_q - 1'b1;
      if (int_edge && !serial_bit_clock_o) begin
        serial_bit_clock_o <= 1'b1;
        if (int_pulses_q == '0) begin
          tag_cap_q <= pins_q.daisy_chain_input;
        end
      end else if (int_edge) begin
        serial_bit_clock_o <= 1'b0;
        int_pulses_q       <= int_pulses_q + 5'h01;
        if (int_pulses_q == LAST_PULSE) begin
          int_active_q <= 1'b0;
          int_done_q   <= 1'b1;
        end
      end
    end
  end

  // External bit clock framing; shifting is done in the shared shifter
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ext_cnt_q     <= '0;
      ext_en_prev_q <= 1'b0;
      frame_q       <= 1'b0;
    end else begin
      ext_en_prev_q <= ext_en;
      if (!ext_clk_mode) begin
        ext_cnt_q <= '0;
        frame_q   <= 1'b0;
      end else if (ext_arm || ext_reload) begin
        ext_cnt_q <= '0;
        frame_q   <= 1'b0;
      end else if (ext_en && ext_rise) begin
        frame_q <= (ext_cnt_q == 2'h0);
        if (ext_cnt_q != 2'h2) begin
          ext_cnt_q <= ext_cnt_q + 2'h1;
        end
      end
    end
  end

  // One shifter serves both clock sources; MSB leaves first
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      shift_q <= RESULT_RST;
      ser_q   <= 1'b0;
    end else if ((start_go && int_clk_mode) || ext_arm || ext_reload) begin
      shift_q <= (ext_reload) ? fifo_data : result_q;
    end else if (int_active_q) begin
      ser_q <= shift_q[RESULT_W-1];
      if (int_edge && serial_bit_clock_o) begin
        shift_q <= {shift_q[RESULT_W-2:0], 1'b0};
      end
    end else if (int_done_q && int_clk_mode) begin
      ser_q <= tag_cap_q;
    end else if (ext_en && ext_rise && ext_cnt_q != 2'h0) begin
      ser_q   <= shift_q[RESULT_W-1];
      shift_q <= {shift_q[RESULT_W-2:0], pins_q.daisy_chain_input};
    end
  end

  // Output stage: every pin and enable leaves from a flop
  wire par_en = pins_q.output_format_select & read_sel;
  wire [BYTE_W-1:0] byte_mux = pins_q.byte_select ? result_q[BYTE_W-1:0]
                                                  : result_q[RESULT_W-1:BYTE_W];
  wire ser_oe = int_clk_mode ? ~busy_n : ext_en;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      parallel_data         <= '0;
      parallel_data_oe      <= '0;
      serial_bit_clock_oe   <= 1'b0;
      serial_output_line    <= 1'b0;
      serial_output_line_oe <= 1'b0;
      frame_pulse           <= 1'b0;
    end else begin
      parallel_data         <= byte_mux;
      parallel_data_oe      <= {BYTE_W{par_en}};
      serial_bit_clock_oe   <= int_clk_mode;
      serial_output_line    <= ser_q;
      serial_output_line_oe <= ser_oe;
      frame_pulse           <= frame_q & serial_mode;
    end
  end

  adcrp_fifo #(
    .WIDTH (RESULT_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .in_data   (sample_data),
    .in_valid  (sample_valid),
    .in_ready  (sample_ready),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (conv_end)
  );

endmodule : adcrp_readout

`default_nettype wire

// ### tb/adcrp_readout_chk.sv
`timescale 1ns/100ps
`default_nettype none
module adcrp_readout_chk
  import adcrp_pkg::*;
(
  input wire logic              clk,
  input wire logic              sys_rst,
  input wire logic              chip_select_n,
  input wire logic              read_convert,
  input wire logic              output_format_select,
  input wire logic              clock_source_select,
  input wire logic              busy_n,
  input wire logic [BYTE_W-1:0] parallel_data_oe,
  input wire logic              serial_bit_clock_o,
  input wire logic              serial_bit_clock_oe,
  input wire logic              serial_output_line_oe
);
  logic [11:0] low_q;
  logic [11:0] low_d;
  logic        rd_w;
  logic        sm_w;
  assign rd_w  = !chip_select_n && read_convert;
  assign sm_w  = !output_format_select;
  // Saturates so an empty FIFO stall cannot wrap it
  assign low_d = busy_n ? 12'h000 : low_q + {11'h000, low_q != 12'hFFF};
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      low_q <= 12'h000;
    end else begin
      low_q <= low_d;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_par_on: assert property ((output_format_select && rd_w)[*4] |-> parallel_data_oe == 8'hFF)
    else $error("parallel bus not driven");
  a_par_off: assert property ((sm_w || !rd_w)[*4] |-> parallel_data_oe == 8'h00)
    else $error("parallel bus driven");
  a_line_own: assert property ((sm_w && !clock_source_select)[*4] |-> serial_output_line_oe == !$past(busy_n))
    else $error("serial line enable not following busy");
  a_clk_drive: assert property ((sm_w && !clock_source_select)[*4] |-> serial_bit_clock_oe)
    else $error("bit clock not driven");
  a_line_far_on: assert property ((sm_w && clock_source_select && rd_w)[*4] |-> serial_output_line_oe)
    else $error("serial line not driven");
  a_line_far_off: assert property ((clock_source_select && !rd_w)[*4] |-> !serial_output_line_oe && !serial_bit_clock_oe)
    else $error("serial pins driven while off");
  a_clk_high: assert property (serial_bit_clock_oe && $rose(serial_bit_clock_o) |-> ##26 serial_bit_clock_o ##1 !serial_bit_clock_o)
    else $error("bit clock high time wrong");
  a_clk_idle: assert property (serial_bit_clock_oe && busy_n && $past(busy_n) |-> !serial_bit_clock_o)
    else $error("bit clock runs while idle");
  a_busy_len: assert property ($rose(busy_n) |-> low_q >= 12'h3E8)
    else $error("busy low too short");
  a_conv_start: assert property ($fell(busy_n) |-> !$past(chip_select_n, 3) && !$past(read_convert, 3))
    else $error("conversion without request");
endmodule : adcrp_readout_chk
bind adcrp_readout adcrp_readout_chk chk_u (.clk(clk), .sys_rst(sys_rst),
  .chip_select_n(chip_select_n), .read_convert(read_convert), .busy_n(busy_n),
  .output_format_select(output_format_select), .clock_source_select(clock_source_select),
  .parallel_data_oe(parallel_data_oe), .serial_bit_clock_o(serial_bit_clock_o),
  .serial_bit_clock_oe(serial_bit_clock_oe), .serial_output_line_oe(serial_output_line_oe));
`default_nettype wire

// ### tb/adcrp_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module adcrp_host_model (
  output var logic        bit_clk,
  input  wire logic       line,
  input  wire logic       frame,
  output var logic [18:0] line_h,
  output var logic [18:0] frm_h
);
  initial begin
    bit_clk = 1'b0;
    line_h  = '0;
    frm_h   = '0;
  end
  // Clock stands low between bursts, so a result load is never lost
  task automatic burst(input int n);
    #7;
    for (int i = 0; i < n; i++) begin
      #40;
      line_h = {line_h[17:0], line};
      frm_h  = {frm_h[17:0], frame};
      #40 bit_clk = 1'b1;
      #80 bit_clk = 1'b0;
    end
    #40;
    line_h = {line_h[17:0], line};
    frm_h  = {frm_h[17:0], frame};
  endtask : burst
endmodule : adcrp_host_model
`default_nettype wire

// ### tb/adcrp_readout_bench.sv
`timescale 1ns/100ps
`default_nettype none
module adcrp_readout_bench
  import adcrp_pkg::*;
;
  logic clk, sys_rst, chip_select_n, read_convert, byte_select, output_format_select;
  logic clock_source_select, daisy_chain_input, sample_valid, sample_ready, busy_n;
  logic serial_bit_clock_o, serial_bit_clock_oe, serial_output_line, serial_output_line_oe;
  logic frame_pulse, host_clk, bit_w, cont_sel;
  logic [15:0] sample_data;
  logic [7:0]  parallel_data, parallel_data_oe;
  logic [18:0] line_h, frm_h;
  int          n_mismatch, compares, cyc;
  assign bit_w = serial_bit_clock_oe ? serial_bit_clock_o : host_clk;
  adcrp_readout dut_u (.clk, .sys_rst, .chip_select_n, .read_convert, .byte_select,
    .output_format_select, .clock_source_select, .continuous_convert_select(cont_sel),
    .power_down_input(1'b0), .daisy_chain_input, .serial_bit_clock_i(bit_w), .sample_data,
    .sample_valid, .sample_ready, .busy_n, .parallel_data, .parallel_data_oe,
    .serial_bit_clock_o, .serial_bit_clock_oe, .serial_output_line, .serial_output_line_oe,
    .frame_pulse);
  adcrp_host_model host_u (.bit_clk(host_clk), .line(serial_output_line), .frame(frame_pulse),
    .line_h, .frm_h);
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic final_report();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : final_report
  // Ceiling covers 34 conversions with margin
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 45000) begin
      n_mismatch++;
      final_report();
    end
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  function automatic logic [15:0] wd(input int i);
    return {8'(i) ^ 8'h5A, 8'(i)};
  endfunction : wd
  task automatic step(input int n);
    repeat (n) @(posedge clk);
  endtask : step
  task automatic conv();
    @(posedge clk);
    chip_select_n <= 1'b0;
    read_convert  <= 1'b0;
    for (int i = 0; i < 20 && busy_n !== 1'b0; i++) @(posedge clk);
    read_convert <= 1'b1;
  endtask : conv
  task automatic wdone();
    for (int i = 0; i < 1500 && busy_n !== 1'b1; i++) @(posedge clk);
  endtask : wdone
  task automatic rd(input logic [15:0] exp);
    chip_select_n <= 1'b0;
    byte_select   <= 1'b0;
    step(4);
    #1;
    chk(parallel_data_oe, 8'hFF);
    chk(parallel_data, exp[15:8]);
    @(posedge clk) byte_select <= 1'b1;
    step(4);
    #1;
    chk(parallel_data, exp[7:0]);
    @(posedge clk) chip_select_n <= 1'b1;
    step(4);
    #1;
    chk(parallel_data_oe, 8'h00);
  endtask : rd
  task automatic t_fill();
    int n = 0;
    sample_valid <= 1'b1;
    sample_data  <= wd(0);
    repeat (40) begin
      @(posedge clk);
      if (sample_ready === 1'b1) begin
        n++;
        sample_data <= wd(n);
      end
    end
    sample_valid <= 1'b0;
    #1;
    chk(16'(n), 16'd32);
    chk(sample_ready, 1'b0);
    $display("fill done");
  endtask : t_fill
  task automatic t_par();
    for (int k = 0; k < 31; k++) begin
      conv();
      if (k == 0) begin
        step(100);
        read_convert <= 1'b0;
        step(4);
        read_convert <= 1'b1;
      end
      wdone();
      rd(wd(k));
      chk(busy_n, 1'b1);
    end
    $display("parallel done");
  endtask : t_par
  // Samples the line at each rise of the internal bit clock until busy returns
  task automatic grab(output logic [15:0] sh, output int np, output logic ln);
    logic p;
    sh = 16'h0000;
    np = 0;
    p  = 1'b0;
    ln = 1'b0;
    for (int i = 0; i < 1500 && busy_n !== 1'b1; i++) begin
      @(posedge clk);
      #1;
      if (serial_bit_clock_o && !p) begin
        sh = {sh[14:0], serial_output_line};
        np++;
      end
      if (!serial_bit_clock_o && p) daisy_chain_input <= 1'b0;
      p = serial_bit_clock_o;
      if (!busy_n) ln = serial_output_line;
    end
  endtask : grab
  task automatic t_own_clk();
    logic [15:0] sh;
    int          np;
    logic        ln;
    @(posedge clk);
    output_format_select <= 1'b0;
    daisy_chain_input    <= 1'b1;
    step(4);
    conv();
    grab(sh, np, ln);
    chk(16'(np), 16'd16);
    chk(sh, wd(30));
    chk(ln, 1'b1);
    $display("own clock done");
  endtask : t_own_clk
  task automatic t_far_clk();
    @(posedge clk);
    chip_select_n       <= 1'b1;
    clock_source_select <= 1'b1;
    daisy_chain_input   <= 1'b1;
    step(6);
    chip_select_n <= 1'b0;
    step(6);
    host_u.burst(18);
    chk(frm_h[17:16], 2'b10);
    chk(line_h[16:1], wd(31));
    chk(line_h[0], 1'b1);
    chk(sample_ready, 1'b1);
    $display("far clock done");
  endtask : t_far_clk
  task automatic t_cont();
    logic [15:0] sh;
    int          np;
    logic        ln;
    int          n;
    @(posedge clk);
    clock_source_select <= 1'b0;
    sample_valid        <= 1'b1;
    sample_data         <= wd(40);
    @(posedge clk);
    sample_data <= wd(41);
    @(posedge clk);
    sample_valid <= 1'b0;
    cont_sel     <= 1'b1;
    step(4);
    // Falling edge starts one cycle sooner than the two-cycle level start
    read_convert <= 1'b0;
    for (n = 0; n < 20 && busy_n !== 1'b0; n++) @(posedge clk);
    chk(16'(n), 16'd4);
    wdone();
    for (int i = 0; i < 20 && busy_n !== 1'b0; i++) @(posedge clk);
    read_convert      <= 1'b1;
    daisy_chain_input <= 1'b1;
    grab(sh, np, ln);
    chk(sh, wd(40));
    chk(16'(np), 16'd16);
    chk(ln, 1'b1);
    cont_sel <= 1'b0;
    $display("continuous done");
  endtask : t_cont
  initial begin
    sys_rst = 1'b1;
    chip_select_n = 1'b1;
    read_convert = 1'b1;
    byte_select = 1'b0;
    output_format_select = 1'b1;
    clock_source_select = 1'b0;
    daisy_chain_input = 1'b0;
    sample_valid = 1'b0;
    cont_sel = 1'b0;
    sample_data = 16'h0000;
    n_mismatch = 0;
    compares = 0;
    cyc = 0;
    step(2);
    sys_rst <= 1'b0;
    step(4);
    t_fill();
    t_par();
    t_own_clk();
    t_far_clk();
    t_cont();
    final_report();
  end
endmodule : adcrp_readout_bench
`default_nettype wire
